// ---- design/irm_params.svh ----
// register map, field positions, reset values and fixed slot numbers
`ifndef IRM_PARAMS_SVH
`define IRM_PARAMS_SVH

// register indices; byte address is four times the index
`define IRM_IDX_ROUTE      10'h0C0
`define IRM_IDX_STATUS     10'h0E0
`define IRM_IDX_MASK       10'h0E1
`define IRM_ADDR_ROUTE     12'h300
`define IRM_ADDR_STATUS    12'h380
`define IRM_ADDR_MASK      12'h384

`define IRM_ROUTE_RESET    8'h00
`define IRM_STATUS_RESET   5'h00
`define IRM_MASK_RESET     5'h00

// routing register field positions
`define IRM_BIT_PARALLEL   0
`define IRM_BIT_RTC_PIN    1
`define IRM_BIT_SCI_PIN    2
`define IRM_BIT_SCI_POL    3
`define IRM_BIT_SCI_OD     4
`define IRM_BIT_EVT_LO     5
`define IRM_BIT_EVT_HI     6
`define IRM_BIT_SMI_PIN    7

// status bit positions
`define IRM_ST_CFG_WR      0
`define IRM_ST_RSVD_SEL    1
`define IRM_ST_RTC_LOST    2
`define IRM_ST_SCI_LOST    3
`define IRM_ST_SMI_LOST    4

// fixed interrupt numbers
`define IRM_SMI_SLOT       4'h2
`define IRM_IRQ9           4'h9
`define IRM_IRQ14          4'hE
`define IRM_IRQ15          4'hF

`endif

// ---- design/irm_pin_drv.sv ----
// registered pin driver with selectable polarity and push-pull or open-drain type
`timescale 1ns/1ps
`default_nettype none

module irm_pin_drv
  import irm_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire irm_pin_req_type req,
  output var  logic            pin_o,
  output var  logic            pin_oe_n
);

  irm_pin_state_type s_r;
  irm_pin_state_type s_nxt;
  logic              level;

  always_comb begin
    s_nxt = s_r;
    level = req.assert_lvl ? req.active_high : ~req.active_high;
    if (!req.enable) begin
      s_nxt.pin_o    = 1'b0;
      s_nxt.pin_oe_n = 1'b1;
    end else if (req.open_drain) begin
      // only ever pulls low, released for a high level
      s_nxt.pin_o    = 1'b0;
      s_nxt.pin_oe_n = level;
    end else begin
      s_nxt.pin_o    = level;
      s_nxt.pin_oe_n = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{pin_o: 1'b0, pin_oe_n: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pin_o    = s_r.pin_o;
  assign pin_oe_n = s_r.pin_oe_n;

endmodule // irm_pin_drv

`default_nettype wire

// ---- design/irm_pkg.sv ----
// types shared by the interrupt routing mux
package irm_pkg;

  typedef enum logic [1:0] {
    IRM_EVT_PME  = 2'b00,
    IRM_EVT_SCI  = 2'b01,
    IRM_EVT_IRQ9 = 2'b10,
    IRM_EVT_RSVD = 2'b11
  } irm_evt_sel_type;

  // routing register layout, msb first
  typedef struct packed {
    logic            smi_pin;
    irm_evt_sel_type evt_sel;
    logic            sci_od;
    logic            sci_pol;
    logic            sci_pin;
    logic            rtc_pin;
    logic            parallel;
  } irm_route_type;

  typedef enum logic [1:0] {
    IRM_SEL_NONE   = 2'b00,
    IRM_SEL_ROUTE  = 2'b01,
    IRM_SEL_STATUS = 2'b10,
    IRM_SEL_MASK   = 2'b11
  } irm_reg_sel_type;

  // request to one configurable pin driver
  typedef struct packed {
    logic assert_lvl;
    logic active_high;
    logic open_drain;
    logic enable;
  } irm_pin_req_type;

  typedef struct packed {
    logic pin_o;
    logic pin_oe_n;
  } irm_pin_state_type;

endpackage

// ---- design/irm_route_mux.sv ----
// interrupt routing mux: serial frame or pin steering, shared event pin, apb registers
`timescale 1ns/1ps
`default_nettype none
`include "irm_params.svh"

module irm_route_mux
  import irm_pkg::*;
#(
  parameter int unsigned AW          = 12,
  parameter int unsigned NIRQ        = 16,
  parameter logic [3:0]  RTC_IRQ_NUM = 4'h8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [AW-1:0]     paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  output var  logic              irq_out,
  // interrupt sources, active-high levels
  input  wire logic [NIRQ-1:0]   irq_src,
  input  wire logic              rtc_irq,
  input  wire logic              sci_req,
  input  wire logic              smi_req,
  input  wire logic              pme_req,
  input  wire logic [3:0]        sci_irq_num,
  input  wire logic              acpi_unit_enable,
  input  wire logic              standby_trickle_power,
  input  wire logic              smi_active_high,
  input  wire logic              smi_open_drain,
  // serial frame engine side
  output var  logic [NIRQ-1:0]   frame_slots,
  input  wire logic              frame_engine_o,
  input  wire logic              frame_engine_oe_n,
  // pins
  output var  logic              framed_interrupt_line_o,
  output var  logic              framed_interrupt_line_oe_n,
  output var  logic              bus_clk_pin_o,
  output var  logic              bus_clk_pin_oe_n,
  output var  logic [NIRQ-1:0]   irq_pin_o,
  output var  logic [NIRQ-1:0]   irq_pin_oe_n,
  output var  logic              event_pin_o,
  output var  logic              event_pin_oe_n,
  output var  logic              mgmt_interrupt_pin_n_o,
  output var  logic              mgmt_interrupt_pin_n_oe_n,
  output var  logic              bios_buf_en
);

  localparam int unsigned NST = 5;

  typedef struct packed {
    irm_route_type   route;
    logic [NST-1:0]  status;
    logic [NST-1:0]  mask;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            irq_out;
    logic [NIRQ-1:0] slots;
    logic [NIRQ-1:0] pins;
    logic [NIRQ-1:0] pins_oe_n;
    logic            frame_o;
    logic            frame_oe_n;
    logic            clk_o;
    logic            clk_oe_n;
    logic            bios_buf_en;
  } irm_state_type;

  irm_state_type   s_r;
  irm_state_type   s_nxt;
  irm_pin_req_type evt_req;
  irm_pin_req_type mgmt_req;

  function automatic irm_reg_sel_type reg_sel(input logic [AW-1:0] a);
    if (a == AW'(`IRM_ADDR_ROUTE)) begin
      reg_sel = IRM_SEL_ROUTE;
    end else if (a == AW'(`IRM_ADDR_STATUS)) begin
      reg_sel = IRM_SEL_STATUS;
    end else if (a == AW'(`IRM_ADDR_MASK)) begin
      reg_sel = IRM_SEL_MASK;
    end else begin
      reg_sel = IRM_SEL_NONE;
    end
  endfunction

  logic            setup_ph;
  logic            access_ph;
  logic            wr_route;
  logic            rd_status;
  logic            serial_ok;
  logic            sci_on_evt;
  logic            irq9_on_evt;
  logic            sci_pol;
  logic            sci_od;
  logic [NIRQ-1:0] legacy;
  logic [NIRQ-1:0] ser_vec;
  logic [NIRQ-1:0] par_vec;
  logic [NIRQ-1:0] pin_en;
  logic [NST-1:0]  ev;
  irm_route_type   c;

  always_comb begin
    s_nxt       = s_r;
    setup_ph    = psel & ~penable;
    access_ph   = psel & penable & s_r.pready;
    wr_route    = access_ph & pwrite & (reg_sel(paddr) == IRM_SEL_ROUTE);
    rd_status   = access_ph & ~pwrite & (reg_sel(paddr) == IRM_SEL_STATUS);

    // apb: zero wait state, answer registered during setup
    s_nxt.pready  = setup_ph;
    s_nxt.pslverr = setup_ph & (reg_sel(paddr) == IRM_SEL_NONE);
    if (setup_ph) begin
      if (reg_sel(paddr) == IRM_SEL_ROUTE) begin
        s_nxt.prdata = {24'h000000, s_r.route};
      end else if (reg_sel(paddr) == IRM_SEL_STATUS) begin
        s_nxt.prdata = {{(32-NST){1'b0}}, s_r.status};
      end else if (reg_sel(paddr) == IRM_SEL_MASK) begin
        s_nxt.prdata = {{(32-NST){1'b0}}, s_r.mask};
      end else begin
        s_nxt.prdata = 32'h00000000;
      end
    end
    if (access_ph && pwrite) begin
      if (reg_sel(paddr) == IRM_SEL_ROUTE) begin
        s_nxt.route = irm_route_type'(pwdata[7:0]);
      end else if (reg_sel(paddr) == IRM_SEL_MASK) begin
        s_nxt.mask = pwdata[NST-1:0];
      end
    end

    // routing works from the value being written this edge
    c         = s_nxt.route;
    serial_ok = ~standby_trickle_power;
    // polarity and type bits only count while the acpi unit is enabled
    sci_pol   = acpi_unit_enable & c.sci_pol;
    sci_od    = acpi_unit_enable & c.sci_od;
    sci_on_evt  = (c.evt_sel == IRM_EVT_SCI);
    irq9_on_evt = (c.evt_sel == IRM_EVT_IRQ9);
    legacy      = irq_src;
    if (irq9_on_evt) begin
      legacy[`IRM_IRQ9] = 1'b0;
    end

    for (int k = 0; k < NIRQ; k++) begin
      ser_vec[k] = (~c.parallel & legacy[k])
                 | (~c.rtc_pin & rtc_irq & (4'(k) == RTC_IRQ_NUM))
                 | (~c.sci_pin & ~sci_on_evt & sci_req & (4'(k) == sci_irq_num))
                 | (~c.smi_pin & smi_req & (4'(k) == `IRM_SMI_SLOT));
      par_vec[k] = (c.parallel & legacy[k])
                 | (c.rtc_pin & rtc_irq & (4'(k) == RTC_IRQ_NUM))
                 | (c.sci_pin & ~sci_on_evt & sci_req & (4'(k) == sci_irq_num));
      pin_en[k]  = c.parallel
                 | (c.rtc_pin & (4'(k) == RTC_IRQ_NUM))
                 | (c.sci_pin & ~sci_on_evt & (4'(k) == sci_irq_num));
    end
    // irq14 and irq15 leave on the shared pins in parallel mode
    if (c.parallel) begin
      pin_en[`IRM_IRQ14] = 1'b0;
      pin_en[`IRM_IRQ15] = 1'b0;
    end

    s_nxt.slots     = serial_ok ? ser_vec : '0;
    s_nxt.pins      = par_vec & pin_en;
    s_nxt.pins_oe_n = ~pin_en;

    if (c.parallel) begin
      s_nxt.frame_o    = par_vec[`IRM_IRQ15];
      s_nxt.frame_oe_n = 1'b0;
      s_nxt.clk_o      = par_vec[`IRM_IRQ14];
      s_nxt.clk_oe_n   = 1'b0;
    end else begin
      s_nxt.frame_o    = serial_ok & frame_engine_o;
      s_nxt.frame_oe_n = ~serial_ok | frame_engine_oe_n;
      s_nxt.clk_o      = 1'b0;
      s_nxt.clk_oe_n   = 1'b1;
    end
    s_nxt.bios_buf_en = ~c.parallel;

    // events: a serial-routed rtc, sci or smi request that cannot be framed is flagged lost
    ev = '0;
    ev[`IRM_ST_CFG_WR]   = wr_route;
    ev[`IRM_ST_RSVD_SEL] = wr_route & (c.evt_sel == IRM_EVT_RSVD);
    ev[`IRM_ST_RTC_LOST] = ~serial_ok & ~c.rtc_pin & rtc_irq;
    ev[`IRM_ST_SCI_LOST] = ~serial_ok & ~c.sci_pin & ~sci_on_evt & sci_req;
    ev[`IRM_ST_SMI_LOST] = ~serial_ok & ~c.smi_pin & smi_req;
    // read clears, a new event in the same cycle survives
    s_nxt.status  = (rd_status ? '0 : s_r.status) | ev;
    s_nxt.irq_out = |(s_nxt.status & s_nxt.mask);

    // shared event pin function and driver type
    case (c.evt_sel)
      IRM_EVT_PME: begin
        evt_req = '{assert_lvl: pme_req, active_high: 1'b0,
                    open_drain: 1'b1, enable: 1'b1};
      end
      IRM_EVT_SCI: begin
        evt_req = '{assert_lvl: sci_req, active_high: sci_pol,
                    open_drain: sci_od, enable: 1'b1};
      end
      IRM_EVT_IRQ9: begin
        evt_req = '{assert_lvl: irq_src[`IRM_IRQ9], active_high: 1'b1,
                    open_drain: 1'b0, enable: 1'b1};
      end
      default: begin
        evt_req = '{assert_lvl: 1'b0, active_high: 1'b0,
                    open_drain: 1'b0, enable: 1'b0};
      end
    endcase

    // management pin type from the gpio side
    mgmt_req = '{assert_lvl: smi_req, active_high: smi_active_high,
                 open_drain: smi_open_drain, enable: c.smi_pin};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r             <= '0;
      s_r.route       <= irm_route_type'(`IRM_ROUTE_RESET);
      s_r.status      <= `IRM_STATUS_RESET;
      s_r.mask        <= `IRM_MASK_RESET;
      s_r.pins_oe_n   <= '1;
      s_r.frame_oe_n  <= 1'b1;
      s_r.clk_oe_n    <= 1'b1;
      s_r.bios_buf_en <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  irm_pin_drv u_event_pin (
    .pclk     (pclk),
    .presetn  (presetn),
    .req      (evt_req),
    .pin_o    (event_pin_o),
    .pin_oe_n (event_pin_oe_n)
  );

  irm_pin_drv u_mgmt_pin (
    .pclk     (pclk),
    .presetn  (presetn),
    .req      (mgmt_req),
    .pin_o    (mgmt_interrupt_pin_n_o),
    .pin_oe_n (mgmt_interrupt_pin_n_oe_n)
  );

  assign prdata                     = s_r.prdata;
  assign pready                     = s_r.pready;
  assign pslverr                    = s_r.pslverr;
  assign irq_out                    = s_r.irq_out;
  assign frame_slots                = s_r.slots;
  assign framed_interrupt_line_o    = s_r.frame_o;
  assign framed_interrupt_line_oe_n = s_r.frame_oe_n;
  assign bus_clk_pin_o              = s_r.clk_o;
  assign bus_clk_pin_oe_n           = s_r.clk_oe_n;
  assign irq_pin_o                  = s_r.pins;
  assign irq_pin_oe_n               = s_r.pins_oe_n;
  assign bios_buf_en                = s_r.bios_buf_en;

endmodule // irm_route_mux

`default_nettype wire

// ---- sim/irm_host_model.sv ----
// host side: collects frame slots, runs a framer drive that never rests
`timescale 1ns/1ps
`default_nettype none

module irm_host_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] frame_slots,
  output var  logic        frame_engine_o,
  output var  logic        frame_engine_oe_n,
  output var  logic [15:0] host_seen
);
  // toggling drive so a stale level is never mistaken for data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_engine_o    <= 1'b0;
      frame_engine_oe_n <= 1'b1;
      host_seen         <= 16'h0000;
    end else begin
      frame_engine_o    <= ~frame_engine_o;
      frame_engine_oe_n <= 1'b0;
      host_seen         <= frame_slots;
    end
  end
endmodule // irm_host_model

`default_nettype wire

// ---- sim/irm_route_assertions.sv ----
// concurrent checks of interrupt steering, event pin drive and apb timing
`timescale 1ns/1ps
`default_nettype none

module irm_route_assertions #(
  parameter int unsigned AW          = 12,
  parameter int unsigned NIRQ        = 16,
  parameter logic [3:0]  RTC_IRQ_NUM = 4'h8
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [AW-1:0]   paddr,
  input wire logic [31:0]     pwdata,
  input wire logic            pready,
  input wire logic [NIRQ-1:0] irq_src,
  input wire logic            rtc_irq,
  input wire logic            sci_req,
  input wire logic            smi_req,
  input wire logic            pme_req,
  input wire logic            acpi_unit_enable,
  input wire logic            standby_trickle_power,
  input wire logic            smi_active_high,
  input wire logic            smi_open_drain,
  input wire logic [NIRQ-1:0] frame_slots,
  input wire logic            framed_interrupt_line_o,
  input wire logic            framed_interrupt_line_oe_n,
  input wire logic            event_pin_o,
  input wire logic            event_pin_oe_n,
  input wire logic            mgmt_interrupt_pin_n_o,
  input wire logic            mgmt_interrupt_pin_n_oe_n,
  input wire logic            bios_buf_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [7:0] rt_r;

  // shadow of the routing register, updated at the completing write edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rt_r <= 8'h00;
    else if (psel && penable && pready && pwrite && paddr == AW'(12'h300)) rt_r <= pwdata[7:0];
  end

  sequence s_setup;
    psel && !penable;
  endsequence

  a_ready_zero: assert property (s_setup |=> pready)
    else $error("access cycle without ready");
  a_bios_par: assert property (bios_buf_en == !rt_r[0])
    else $error("bios buffer enable wrong");
  a_par_pins: assert property (rt_r[0] |-> !framed_interrupt_line_oe_n &&
    framed_interrupt_line_o == $past(irq_src[15])) else $error("irq15 pin wrong");
  a_rtc_frame: assert property (!rt_r[1] && $past(rtc_irq) &&
    !$past(standby_trickle_power) |-> frame_slots[RTC_IRQ_NUM]) else $error("rtc slot lost");
  a_rtc_pin: assert property (rt_r[1] && !$past(irq_src[RTC_IRQ_NUM]) |->
    !frame_slots[RTC_IRQ_NUM]) else $error("rtc still framed");
  a_smi_frame: assert property (!rt_r[7] && $past(smi_req) &&
    !$past(standby_trickle_power) |-> frame_slots[2]) else $error("smi slot lost");
  a_mgmt_pin: assert property (rt_r[7] && !$past(smi_open_drain) |->
    !mgmt_interrupt_pin_n_oe_n && mgmt_interrupt_pin_n_o == ($past(smi_req) ~^
    $past(smi_active_high))) else $error("management pin drive wrong");
  a_mgmt_idle: assert property (!rt_r[7] |-> mgmt_interrupt_pin_n_oe_n)
    else $error("management pin driven");
  a_trickle: assert property ($past(standby_trickle_power) |-> ~|frame_slots)
    else $error("frame slot under trickle power");
  a_evt_pme: assert property (rt_r[6:5] == 2'b00 |-> !event_pin_o &&
    event_pin_oe_n == !$past(pme_req)) else $error("power event pin wrong");
  a_evt_irq9: assert property (rt_r[6:5] == 2'b10 |-> !event_pin_oe_n &&
    event_pin_o == $past(irq_src[9])) else $error("irq9 event pin wrong");
  a_evt_sci: assert property (rt_r[6:5] == 2'b01 && $past(acpi_unit_enable) |->
    (rt_r[4] ? !event_pin_o && event_pin_oe_n == ($past(sci_req) ~^ rt_r[3])
    : !event_pin_oe_n && event_pin_o == ($past(sci_req) ~^ rt_r[3])))
    else $error("sci event pin wrong");
  a_evt_rsvd: assert property (rt_r[6:5] == 2'b11 |-> event_pin_oe_n)
    else $error("reserved event pin driven");
endmodule // irm_route_assertions

bind irm_route_mux irm_route_assertions #(.AW(AW), .NIRQ(NIRQ), .RTC_IRQ_NUM(RTC_IRQ_NUM))
  i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .irq_src,
  .rtc_irq, .sci_req, .smi_req, .pme_req, .acpi_unit_enable, .standby_trickle_power,
  .smi_active_high, .smi_open_drain, .frame_slots, .framed_interrupt_line_o,
  .framed_interrupt_line_oe_n, .event_pin_o, .event_pin_oe_n, .mgmt_interrupt_pin_n_o,
  .mgmt_interrupt_pin_n_oe_n, .bios_buf_en);

`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for the interrupt routing mux
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; \
  $display("unexpected %s expected %0h seen %0h", n, e, s); end end

module testbench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        rtc_irq = 1'b0, sci_req = 1'b0, smi_req = 1'b0, pme_req = 1'b0;
  logic        standby_trickle_power = 1'b0, smi_active_high = 1'b0, smi_open_drain = 1'b0;
  logic        acpi_unit_enable = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] irq_src = 16'h0000, frame_slots, irq_pin_o, irq_pin_oe_n, host_seen;
  logic        pready, pslverr, irq_out, er, frame_engine_o, frame_engine_oe_n, bios_buf_en;
  logic        framed_interrupt_line_o, framed_interrupt_line_oe_n, bus_clk_pin_o;
  logic        bus_clk_pin_oe_n, event_pin_o, event_pin_oe_n;
  logic        mgmt_interrupt_pin_n_o, mgmt_interrupt_pin_n_oe_n, od, pol, e_o, e_oe;
  logic [1:0]  sel;
  int          err_total = 0, num_checks = 0;

  always #5 pclk = ~pclk;

  irm_route_mux i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq_out, .irq_src, .rtc_irq, .sci_req, .smi_req, .pme_req,
    .sci_irq_num(4'h5), .acpi_unit_enable, .standby_trickle_power, .smi_active_high,
    .smi_open_drain, .frame_slots, .frame_engine_o, .frame_engine_oe_n,
    .framed_interrupt_line_o, .framed_interrupt_line_oe_n, .bus_clk_pin_o, .bus_clk_pin_oe_n,
    .irq_pin_o, .irq_pin_oe_n, .event_pin_o, .event_pin_oe_n, .mgmt_interrupt_pin_n_o,
    .mgmt_interrupt_pin_n_oe_n, .bios_buf_en);
  irm_host_model i_host (.pclk, .presetn, .frame_slots, .frame_engine_o, .frame_engine_oe_n,
    .host_seen);

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #100us;
    err_total++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 12'h300, 32'h0); `CHK("route reset", 32'h0, rd)
    `CHK("bios reset", 1'b1, bios_buf_en)
    xfer(1'b0, 12'h308, 32'h0); `CHK("unmapped", 33'h1_0000_0000, {er, rd})
    xfer(1'b1, 12'h384, 32'h1F);
    xfer(1'b0, 12'h380, 32'h0); `CHK("status idle", 32'h0, rd)
    @(posedge pclk);
    {sci_req, pme_req, irq_src[9]} <= 3'b111;
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, 12'h300, {24'h0, 1'b0, i[3:0], 3'b000});
      settle();
      {sel, od, pol} = i[3:0];
      e_oe = (sel == 2'b11) || (sel == 2'b01 && od && pol);
      e_o = (sel == 2'b10) || (sel == 2'b01 && !od && pol);
      `CHK("event oe_n", e_oe, event_pin_oe_n)
      if (sel != 2'b11) `CHK("event o", e_o, event_pin_o)
      `CHK("sci slot", sel != 2'b01, host_seen[5])
    end
    `CHK("irq raised", 1'b1, irq_out)
    xfer(1'b0, 12'h380, 32'h0); `CHK("status", 32'h3, rd)
    settle(); `CHK("irq cleared", 1'b0, irq_out)
    xfer(1'b1, 12'h384, 32'h0);
    xfer(1'b1, 12'h300, 32'h0);
    settle(); `CHK("irq masked", 1'b0, irq_out)
    xfer(1'b0, 12'h380, 32'h0); `CHK("status masked", 32'h1, rd)
    @(posedge pclk);
    rtc_irq <= 1'b1;
    irq_src[15:14] <= 2'b11;
    xfer(1'b1, 12'h300, 32'h01);
    settle(); `CHK("bios par", 1'b0, bios_buf_en)
    `CHK("irq15 14 pins", 4'b1010, {framed_interrupt_line_o, framed_interrupt_line_oe_n, bus_clk_pin_o, bus_clk_pin_oe_n})
    `CHK("rtc framed", 1'b1, host_seen[8])
    xfer(1'b1, 12'h300, 32'h07);
    settle(); `CHK("rtc pin", 3'b010, {host_seen[8], irq_pin_o[8], irq_pin_oe_n[8]})
    `CHK("sci pin", 2'b10, {irq_pin_o[5], irq_pin_oe_n[5]})
    xfer(1'b1, 12'h300, 32'hFFFF_FFA5);
    xfer(1'b0, 12'h300, 32'h0); `CHK("route readback", 32'hA5, rd)
    @(posedge pclk);
    smi_req <= 1'b1;
    smi_active_high <= 1'b1;
    xfer(1'b1, 12'h300, 32'h0);
    settle(); `CHK("smi slot", 2'b11, {host_seen[2], mgmt_interrupt_pin_n_oe_n})
    `CHK("frame drive", 2'b01, {framed_interrupt_line_oe_n, bios_buf_en})
    xfer(1'b1, 12'h300, 32'h80);
    settle(); `CHK("smi pin", 3'b010, {host_seen[2], mgmt_interrupt_pin_n_o, mgmt_interrupt_pin_n_oe_n})
    xfer(1'b1, 12'h300, 32'h0);
    @(posedge pclk);
    standby_trickle_power <= 1'b1;
    settle(); `CHK("trickle slots", 16'h0000, host_seen)
    `CHK("trickle frame", 1'b1, framed_interrupt_line_oe_n)
    xfer(1'b0, 12'h380, 32'h0); `CHK("lost status", 32'h1D, rd)
    xfer(1'b0, 12'h380, 32'h0); `CHK("lost again", 32'h1C, rd)
    xfer(1'b1, 12'h300, 32'h86);
    xfer(1'b0, 12'h380, 32'h0);
    xfer(1'b0, 12'h380, 32'h0); `CHK("pin routes", 32'h0, rd)
    conclude();
  end
endmodule // testbench

`default_nettype wire
